// file: rtl/atdma_core.sv
// Seven-channel cascaded DMA engine: arbitration, address generation, handshakes
`timescale 1ns/10ps
`default_nettype none
`include "atdma_map.svh"
// Notes on behaviour
// - Two cascaded controllers, seven usable channels
// - Channel 4 is cascade only, never transfers
// - Channels 0-3 move bytes
// - Byte channels: counter A0-A15, page A16-A23
// - Byte channel block at most 64K bytes
// - Channels 5-7 move 16-bit words only
// - Word channels: counter A1-A16, page A17-A23
// - Word channel block at most 128K bytes
// - Word channels never drive A0 high
// - Every channel reaches full 24-bit space
// - Counter carry never bumps the page
// - Channel 2 serves the onboard floppy
// - Three handshakes on the 8-bit connector
// - Four more handshakes on the 16-bit extension
// - Memory cycles carry one wait state
// - I/O cycles carry four wait states
// - Bus cycles timed from 8 MHz clock
// - First controller decodes ports 0000h-000Fh
// - Second controller decodes ports 00C0h-00DFh
// - Page registers decode ports 0080h-009Fh
module atdma_core
(
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 ce_i,
    input  wire logic [7:0]           slot_drq_i,
    input  wire logic                 fdc_drq_i,
    input  wire logic                 fdc_en_i,
    input  wire logic                 prog_we_i,
    input  wire atdma_pkg::atdma_ch_t prog_ch_i,
    input  wire logic [15:0]          prog_addr_i,
    input  wire logic [15:0]          prog_cnt_i,
    input  wire logic [7:0]           prog_page_i,
    input  wire logic                 prog_io_i,
    input  wire logic                 prog_rd_i,
    input  wire logic [15:0]          io_addr_i,
    output logic [7:0]                dack_n_o,
    output logic                      fdc_dack_n_o,
    output logic [23:0]               addr_o,
    output logic                      aen_o,
    output logic                      cmd_o,
    output logic                      io_cyc_o,
    output logic                      mem_rd_o,
    output logic                      word_o,
    output logic                      tc_o,
    output logic [7:0]                active_o,
    output logic                      sel_dma1_o,
    output logic                      sel_dma2_o,
    output logic                      sel_page_o
);
    import atdma_pkg::*;

    // ************************************************************
    // Request synchronisers
    // ************************************************************
    logic [7:0] raw_drq;
    logic [7:0] s1_q;
    logic [7:0] s2_q;
    logic [7:0] s3_q;
    logic [7:0] drq_f_q;

    // Floppy owns channel 2 when present, else the slot line does
    assign raw_drq = {slot_drq_i[7:3], fdc_en_i ? fdc_drq_i : slot_drq_i[2],
                      slot_drq_i[1:0]};

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            s1_q    <= 8'h00;
            s2_q    <= 8'h00;
            s3_q    <= 8'h00;
            drq_f_q <= 8'h00;
        end
        else if (ce_i)
        begin
            s1_q <= raw_drq;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < 8; i++)
            begin
                if (s2_q[i] == s3_q[i])
                begin
                    drq_f_q[i] <= s3_q[i];
                end
            end
        end
    end

    // ************************************************************
    // Bus clock enable
    // ************************************************************
    // Fractional accumulator keeps the mean rate exact at 8 MHz
    logic [7:0] acc_q;
    logic [8:0] acc_sum;
    logic       tick;

    assign acc_sum = {1'b0, acc_q} + {1'b0, `ATDMA_BUS_MHZ};
    assign tick    = ce_i && (acc_sum >= {1'b0, `ATDMA_CORE_MHZ});

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            acc_q <= 8'h00;
        end
        else if (ce_i)
        begin
            acc_q <= tick ? 8'(acc_sum - {1'b0, `ATDMA_CORE_MHZ}) : acc_sum[7:0];
        end
    end

    // ************************************************************
    // Channel state
    // ************************************************************
    logic [7:0][15:0] addr_q;
    logic [7:0][15:0] cnt_q;
    logic [7:0][7:0]  page_q;
    logic [7:0]       io_q;
    logic [7:0]       rd_q;
    logic [7:0]       act_q;
    logic [7:0]       wr_sel;
    logic [7:0]       step_sel;
    logic             step;
    atdma_ch_t        cur_q;

    // Writes to the cascade position are dropped
    assign wr_sel   = prog_we_i ? ((8'h01 << prog_ch_i) & `ATDMA_CH_MASK) : 8'h00;
    assign step_sel = step ? (8'h01 << cur_q) : 8'h00;

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < 8; i++)
            begin
                addr_q[i] <= `ATDMA_ADDR_RST;
                cnt_q[i]  <= `ATDMA_CNT_RST;
                page_q[i] <= `ATDMA_PAGE_RST;
            end
            io_q  <= 8'h00;
            rd_q  <= 8'h00;
            act_q <= 8'h00;
        end
        else if (ce_i)
        begin
            for (int i = 0; i < 8; i++)
            begin
                if (wr_sel[i])
                begin
                    addr_q[i] <= prog_addr_i;
                    cnt_q[i]  <= prog_cnt_i;
                    page_q[i] <= prog_page_i;
                    io_q[i]   <= prog_io_i;
                    rd_q[i]   <= prog_rd_i;
                    act_q[i]  <= 1'b1;
                end
                else if (step_sel[i])
                begin
                    // 16-bit counter wraps inside its page, page untouched
                    addr_q[i] <= addr_q[i] + 16'h0001;
                    cnt_q[i]  <= cnt_q[i] - 16'h0001;
                    if (cnt_q[i] == 16'h0000)
                    begin
                        act_q[i] <= 1'b0;
                    end
                end
            end
        end
    end

    // ************************************************************
    // Cascaded fixed-priority arbiter
    // ************************************************************
    logic [7:0] req;
    logic       gnt_vld;
    atdma_ch_t  gnt_ch;

    // Channels 0-3 win through the cascade slot ahead of 5-7
    assign req     = drq_f_q & act_q & `ATDMA_CH_MASK;
    assign gnt_vld = |req;
    assign gnt_ch  = req[0] ? 3'd0 : req[1] ? 3'd1 : req[2] ? 3'd2 :
                     req[3] ? 3'd3 : req[5] ? 3'd5 : req[6] ? 3'd6 : 3'd7;

    // ************************************************************
    // Address forming
    // ************************************************************
    logic [23:0] byte_addr;
    logic [23:0] word_addr;

    assign byte_addr = {page_q[gnt_ch], addr_q[gnt_ch]};
    assign word_addr = {page_q[gnt_ch][7:1], addr_q[gnt_ch], 1'b0};

    // ************************************************************
    // Transfer sequencer
    // ************************************************************
    atdma_state_t st_q;
    atdma_state_t st_d;
    logic [2:0]   wcnt_q;
    logic [2:0]   cmd_len;
    logic [7:0]   dack_q;
    logic         last_cmd;

    assign cmd_len  = `ATDMA_CMD_BASE + (io_cyc_o ? `ATDMA_WS_IO : `ATDMA_WS_MEM);
    assign last_cmd = (wcnt_q == 3'(cmd_len - 3'd1));
    assign step     = (st_q == ST_CMD) && tick && last_cmd;

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: if (tick && gnt_vld) st_d = ST_ADDR;
            ST_ADDR: if (tick) st_d = ST_CMD;
            ST_CMD:  if (step) st_d = ST_END;
            ST_END:  if (tick) st_d = ST_IDLE;
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            st_q     <= ST_IDLE;
            cur_q    <= 3'd0;
            wcnt_q   <= 3'd0;
            dack_q   <= `ATDMA_DACK_RST;
            addr_o   <= 24'h000000;
            cmd_o    <= 1'b0;
            io_cyc_o <= 1'b0;
            mem_rd_o <= 1'b0;
            word_o   <= 1'b0;
            tc_o     <= 1'b0;
        end
        else if (ce_i)
        begin
            st_q <= st_d;
            tc_o <= step && (cnt_q[cur_q] == 16'h0000);
            if (st_q == ST_IDLE && st_d == ST_ADDR)
            begin
                cur_q    <= gnt_ch;
                dack_q   <= ~(8'h01 << gnt_ch);
                addr_o   <= gnt_ch[2] ? word_addr : byte_addr;
                word_o   <= gnt_ch[2];
                io_cyc_o <= io_q[gnt_ch];
                mem_rd_o <= rd_q[gnt_ch];
            end
            if (st_q == ST_ADDR && tick)
            begin
                cmd_o  <= 1'b1;
                wcnt_q <= 3'd0;
            end
            if (st_q == ST_CMD && tick)
            begin
                wcnt_q <= wcnt_q + 3'd1;
            end
            if (step)
            begin
                cmd_o <= 1'b0;
            end
            if (st_q == ST_END && tick)
            begin
                dack_q <= `ATDMA_DACK_RST;
            end
        end
    end

    // ************************************************************
    // Outputs and port decode
    // ************************************************************
    assign dack_n_o     = dack_q | {5'h00, fdc_en_i, 2'h0};
    assign fdc_dack_n_o = dack_q[`ATDMA_FDC_CH] | ~fdc_en_i;
    assign aen_o        = (st_q != ST_IDLE);
    assign active_o     = act_q;
    assign sel_dma1_o   = (io_addr_i <= `ATDMA_DMA1_HI);
    assign sel_dma2_o   = (io_addr_i >= `ATDMA_DMA2_LO) && (io_addr_i <= `ATDMA_DMA2_HI);
    assign sel_page_o   = (io_addr_i >= `ATDMA_PAGE_LO) && (io_addr_i <= `ATDMA_PAGE_HI);

    // ************************************************************
    // Checks
    // ************************************************************
    logic [2:0] hcnt_q;
    logic [4:0] gap_q;
    logic       seen_q;

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            hcnt_q <= 3'd0;
            gap_q  <= 5'd0;
            seen_q <= 1'b0;
        end
        else if (ce_i)
        begin
            hcnt_q <= !cmd_o ? 3'd0 : (tick ? hcnt_q + 3'd1 : hcnt_q);
            gap_q  <= tick ? 5'd1 : gap_q + 5'd1;
            seen_q <= seen_q | tick;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_cascade_no_ack: assert property (dack_n_o[4])
        else $error("cascade channel acknowledged");
    a_word_even_addr: assert property (aen_o && word_o |-> !addr_o[0] && cur_q[2])
        else $error("word channel drove odd address");
    a_byte_page_map: assert property ($rose(aen_o) && !word_o |->
        addr_o == {page_q[cur_q], addr_q[cur_q]})
        else $error("byte address not page plus counter");
    a_word_page_map: assert property ($rose(aen_o) && word_o |->
        addr_o[23:1] == {page_q[cur_q][7:1], addr_q[cur_q]})
        else $error("word address not page plus shifted counter");
    a_page_held: assert property (!prog_we_i |=> $stable(page_q))
        else $error("page changed without a write");
    a_mem_wait: assert property ($fell(cmd_o) && !io_cyc_o |-> $past(hcnt_q) == 3'd1)
        else $error("memory command length wrong");
    a_io_wait: assert property ($fell(cmd_o) && io_cyc_o |-> $past(hcnt_q) == 3'd4)
        else $error("io command length wrong");
    a_tick_gap: assert property (tick && seen_q && $past(ce_i) |->
        gap_q == 5'd12 || gap_q == 5'd13)
        else $error("bus tick spacing wrong");
    a_grant_prio: assert property ($rose(aen_o) |->
        ($past(req) & ((8'h01 << cur_q) - 8'h01)) == 8'h00 &&
        ($past(req) & (8'h01 << cur_q)) != 8'h00)
        else $error("grant not lowest requesting channel");
endmodule : atdma_core
`default_nettype wire

// file: rtl/atdma_map.svh
// Address decode ranges, channel constants, bus timing and reset values
`ifndef ATDMA_MAP_SVH
`define ATDMA_MAP_SVH
`define ATDMA_CORE_MHZ   8'd100
`define ATDMA_BUS_MHZ    8'd8
`define ATDMA_WS_MEM     3'd1
`define ATDMA_WS_IO      3'd4
`define ATDMA_CMD_BASE   3'd1
`define ATDMA_DMA1_LO    16'h0000
`define ATDMA_DMA1_HI    16'h000F
`define ATDMA_DMA2_LO    16'h00C0
`define ATDMA_DMA2_HI    16'h00DF
`define ATDMA_PAGE_LO    16'h0080
`define ATDMA_PAGE_HI    16'h009F
`define ATDMA_FDC_CH     3'd2
`define ATDMA_CH_MASK    8'hEF
`define ATDMA_ADDR_RST   16'h0000
`define ATDMA_CNT_RST    16'hFFFF
`define ATDMA_PAGE_RST   8'h00
`define ATDMA_DACK_RST   8'hFF
`endif

// file: rtl/atdma_pkg.sv
// Types shared by the DMA address generator
package atdma_pkg;
    typedef logic [2:0] atdma_ch_t;
    typedef enum logic [3:0]
    {
        ST_IDLE = 4'h1,
        ST_ADDR = 4'h2,
        ST_CMD  = 4'h4,
        ST_END  = 4'h8
    } atdma_state_t;
endpackage : atdma_pkg

// file: dv/atdma_adapters.sv
// Adapter-side model: request lines that wait for their acknowledge
`timescale 1ns/10ps
`default_nettype none
module atdma_adapters
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [8:0]  want_i,
    input  wire logic [8:0]  dack_n_i,
    input  wire logic [23:0] addr_i,
    output logic      [8:0]  drq_o,
    output logic      [8:0]  moved_o,
    output logic      [6:0]  la_o
);
    // ****************************************
    // Request and transfer bookkeeping
    // ****************************************
    logic [8:0] ack_q;
    logic [8:0] ack_new;
    // No address strobe on this link; a fresh acknowledge stands in for it
    assign ack_new = ~dack_n_i & ~ack_q;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            drq_o   <= 9'h000;
            ack_q   <= 9'h000;
            moved_o <= 9'h000;
            la_o    <= 7'h00;
        end
        else
        begin
            drq_o   <= want_i;
            ack_q   <= ~dack_n_i;
            // Data counted only once the acknowledge was seen
            moved_o <= ack_q & dack_n_i;
            if (ack_new != 9'h000)
            begin
                la_o <= addr_i[23:17];
            end
        end
    end
endmodule : atdma_adapters
`default_nettype wire

// file: dv/tb_at_dma_address_generation.sv
// Self-checking testbench for the DMA address generator
`timescale 1ns/10ps
`default_nettype none
module tb_at_dma_address_generation;
    import atdma_pkg::*;
    logic clk = 0, rst_n = 0, we = 0, io = 0, fen = 0, rd = 1;
    atdma_ch_t ch = 3'h0;
    logic [15:0] pa = 16'h0000, pc = 16'h0000, ioa = 16'h0000;
    logic [7:0] pp = 8'h00, dack, act;
    logic [8:0] want = 9'h000, drq, moved;
    logic [23:0] addr;
    logic [6:0] la;
    logic fdack, aen, cmd, ioc, mrd, word, tc, s1, s2, sp, aen_q = 0;
    logic [23:0] aq[$];
    logic [8:0] cq[$];
    logic wq[$];
    int lq[$];
    int cl = 0, tcn = 0, mvn = 0, mismatches = 0, comparisons = 0;
    always #5 clk = ~clk;
    atdma_core atdma_core_inst (.core_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1),
        .slot_drq_i(drq[7:0]), .fdc_drq_i(drq[8]), .fdc_en_i(fen), .prog_we_i(we),
        .prog_ch_i(ch), .prog_addr_i(pa), .prog_cnt_i(pc), .prog_page_i(pp),
        .prog_io_i(io), .prog_rd_i(rd), .io_addr_i(ioa), .dack_n_o(dack),
        .fdc_dack_n_o(fdack), .addr_o(addr), .aen_o(aen), .cmd_o(cmd),
        .io_cyc_o(ioc), .mem_rd_o(mrd), .word_o(word), .tc_o(tc), .active_o(act),
        .sel_dma1_o(s1), .sel_dma2_o(s2), .sel_page_o(sp));
    atdma_adapters atdma_adapters_inst (.clk_i(clk), .rst_n_i(rst_n), .want_i(want),
        .dack_n_i({fdack, dack}), .addr_i(addr), .drq_o(drq), .moved_o(moved),
        .la_o(la));
    // ****************************************
    // Grant monitor
    // ****************************************
    // Falling edge keeps the sample clear of the launching edge
    always @(negedge clk)
    begin
        aen_q <= aen;
        if (aen && !aen_q)
        begin
            aq.push_back(addr);
            cq.push_back({fdack, dack});
            wq.push_back(word);
        end
        if (cmd) cl++;
        else if (cl != 0)
        begin
            lq.push_back(cl);
            cl = 0;
        end
        if (tc) tcn++;
        if (moved != 9'h000) mvn++;
    end
    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        comparisons++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
        comparisons++;
        if (g < lo || g > hi)
        begin
            mismatches++;
            $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask : chk_rng
    task automatic arm(input atdma_ch_t c, input logic [15:0] a, input logic [15:0] n,
                       input logic [7:0] p, input logic i);
        @(posedge clk);
        #1 we = 1; ch = c; pa = a; pc = n; pp = p; io = i;
        @(posedge clk);
        #1 we = 0;
    endtask : arm
    // Requests stay up until every listed channel has disarmed or 6000 cycles pass, then 40 more cycles
    task automatic serve(input logic [8:0] w, input logic [7:0] chs);
        int k;
        aq.delete(); cq.delete(); wq.delete(); lq.delete(); tcn = 0; mvn = 0;
        want = w;
        for (k = 0; k < 6000 && (act & chs) != 8'h00; k++) @(posedge clk);
        chk("disarm", 24'h0, {16'h0, act & chs});
        repeat (40) @(posedge clk);
        #1 want = 9'h000;
        repeat (60) @(posedge clk);
    endtask : serve
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        chk("dack", 24'h1FF, {fdack, dack});
        chk("active", 24'h0, {aen, act});
    endtask : t_reset
    task automatic t_decode;
        logic [15:0] ad[6] = '{16'h000F, 16'h0010, 16'h00C0, 16'h00DF, 16'h0080, 16'h00A0};
        logic [2:0] ex[6] = '{3'h4, 3'h0, 3'h2, 3'h2, 3'h1, 3'h0};
        for (int i = 0; i < 6; i++)
        begin
            #1 ioa = ad[i];
            #1 chk("decode", {21'h0, ex[i]}, {21'h0, s1, s2, sp});
        end
    endtask : t_decode
    task automatic t_byte;
        arm(3'h1, 16'hFFFF, 16'h0001, 8'h12, 1'b0);
        serve(9'h002, 8'h02);
        chk("count", 24'h2, aq.size());
        chk("addr0", 24'h12FFFF, aq[0]);
        chk("addr1", 24'h120000, aq[1]);
        chk("grant", 24'h1FD, cq[0]);
        chk("width", 24'h0, wq[0]);
        chk("tc", 24'h1, tcn);
        chk_rng("memcmd", 23, 27, lq[0]);
        chk("kind", 24'h1, {22'h0, ioc, mrd});
        chk("moved", 24'h2, mvn);
    endtask : t_byte
    task automatic t_io;
        #1 rd = 0;
        arm(3'h3, 16'h0010, 16'h0000, 8'hAB, 1'b1);
        serve(9'h008, 8'h08);
        chk("ioaddr", 24'hAB0010, aq[0]);
        chk_rng("iocmd", 59, 66, lq[0]);
        chk("kind", 24'h2, {22'h0, ioc, mrd});
        #1 rd = 1;
    endtask : t_io
    task automatic t_word;
        arm(3'h5, 16'hFFFF, 16'h0001, 8'h35, 1'b0);
        serve(9'h020, 8'h20);
        chk("waddr0", 24'h35FFFE, aq[0]);
        chk("waddr1", 24'h340000, aq[1]);
        chk("wgrant", 24'h1DF, cq[0]);
        chk("wwidth", 24'h1, wq[0]);
        chk("wmoved", 24'h2, mvn);
        chk("upper", 24'h00001A, {17'h0, la});
    endtask : t_word
    task automatic t_cascade;
        arm(3'h4, 16'h0000, 16'h0000, 8'h00, 1'b0);
        @(posedge clk);
        chk("ch4arm", 24'h0, act);
    endtask : t_cascade
    task automatic t_prio;
        arm(3'h7, 16'hFFFF, 16'h0000, 8'hFF, 1'b0);
        arm(3'h3, 16'h0001, 16'h0000, 8'h00, 1'b0);
        arm(3'h0, 16'h0002, 16'h0000, 8'h00, 1'b0);
        serve(9'h089, 8'h89);
        chk("prio0", 24'h1FE, cq[0]);
        chk("prio1", 24'h1F7, cq[1]);
        chk("prio2", 24'h17F, cq[2]);
        chk("top", 24'hFFFFFE, aq[2]);
        chk("upper7", 24'h00007F, {17'h0, la});
    endtask : t_prio
    task automatic t_fdc;
        #1 fen = 1;
        arm(3'h2, 16'h0100, 16'h0000, 8'h0F, 1'b0);
        serve(9'h104, 8'h04);
        chk("fgrant", 24'h0FF, cq[0]);
        chk("faddr", 24'h0F0100, aq[0]);
        #1 fen = 0;
    endtask : t_fdc
    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial
    begin
        repeat (2) @(posedge clk);
        #1 rst_n = 1;
        t_reset();
        t_decode();
        t_byte();
        t_io();
        t_word();
        t_cascade();
        t_prio();
        t_fdc();
        print_verdict();
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        mismatches++;
        print_verdict();
    end
endmodule : tb_at_dma_address_generation
`default_nettype wire
